/* File: bench/osd_amp_model.sv */
// Amplifier output model: the output trips once the offset trim reaches a threshold.
module osd_amp_model
    import osd_pkg::*;
#(
    parameter logic [4:0] TRIP = 5'h0B
)
(
    input  wire logic       ref_clk_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       cal1_in,
    input  wire logic       cal2_in,
    output logic            amp1_comp_out,
    output logic            amp2_comp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] trim1_r = 5'h10;
    logic [4:0] trim2_r = 5'h10;
    // The trim is snooped off the bus, since the analog side sees it as a voltage step.
    always @(posedge ref_clk_in) begin
        if (wr_in && addr_in == OSD_ADDR_AMP1_CTRL0) trim1_r <= wdata_in[4:0];
        if (wr_in && addr_in == OSD_ADDR_AMP2_CTRL0) trim2_r <= wdata_in[4:0];
    end
    // Outside calibration the output level is of no interest, so it rests low.
    assign amp1_comp_out = cal1_in & (trim1_r >= TRIP);
    assign amp2_comp_out = cal2_in & (trim2_r >= TRIP);
endmodule : osd_amp_model

/* File: bench/osd_switch_ctrl_test.sv */
// Self-checking bench for the amplifier switch control decoder.
module osd_switch_ctrl_test
    import osd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] TRIP = 5'h0B;
    localparam logic [2:0] A1C0 = OSD_ADDR_AMP1_CTRL0;
    localparam logic [2:0] A1C1 = OSD_ADDR_AMP1_CTRL1;
    localparam logic [2:0] A2C1 = OSD_ADDR_AMP2_CTRL1;
    localparam logic [2:0] A2C2 = OSD_ADDR_AMP2_CTRL2;
    logic        ref_clk_in;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  addr_in = 3'h0;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [7:0]  rdata_out;
    logic        amp1_comp_in;
    logic        amp2_comp_in;
    osd_amp_sw_t sw1;
    osd_amp_sw_t sw2;
    osd_pin_t    pin1;
    osd_pin_t    pin2;
    logic        cmp1;
    logic        cmp2;
    logic        oe1;
    logic        oe2;
    logic        gsw;
    logic        xpos;
    logic        xneg;
    logic [5:0]  gain;
    int          err_count = 0;
    int          checks = 0;

    osd_switch_ctrl dut (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .amp1_comp_in(amp1_comp_in), .amp2_comp_in(amp2_comp_in),
        .amp1_sw_out(sw1), .amp2_sw_out(sw2), .amp1_comparator_route_switch_out(cmp1),
        .amp1_output_enable_out(oe1), .amp2_output_enable_out(oe2),
        .amp2_comparator_route_switch_out(cmp2), .amp2_gain_network_switch_out(gsw),
        .amp2_cross_feed_positive_switch_out(xpos),
        .amp2_cross_feed_negative_switch_out(xneg), .amp2_gain_out(gain),
        .amp1_pin_out(pin1), .amp2_pin_out(pin2));

    osd_amp_model #(.TRIP(TRIP)) model (
        .ref_clk_in(ref_clk_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .cal1_in(sw1.cal_short), .cal2_in(sw2.cal_short),
        .amp1_comp_out(amp1_comp_in), .amp2_comp_out(amp2_comp_in));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd

    task automatic results();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        rd(A1C1, d);
        chk(16'(d), 16'(OSD_RST_CTRL1));
        rd(A2C2, d);
        chk(16'(d), 16'(OSD_RST_CTRL2));
        rd(3'h6, d);
        chk(16'(d), 16'h0000);
        chk(16'(pin1), 16'h0000);
    endtask : t_reset

    task automatic t_amp1();
        for (int i = 0; i < 4; i++) begin
            wr(A1C1, {4'h0, 2'(i), 2'b01});
            chk(16'(pin1), 16'({2'(i), 1'b1}));
            chk(16'(sw1.feedback), 16'h0000);
        end
        wr(A1C1, 8'h41);
        chk(16'(sw1.feedback), 16'h0001);
        wr(A1C1, 8'h4C);
        chk(16'(sw1.feedback), 16'h0000);
        chk(16'(pin1), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(A1C1, {2'b00, 2'(i), 4'b0101});
            wr(A2C1, {2'b00, 2'(i), 4'b0101});
            chk(16'(sw1.refs), 16'(i == 0 ? 3'b000 : 3'b100 >> (i - 1)));
            chk(16'(sw2.refs), 16'(i == 0 ? 3'b000 : 3'b100 >> (i - 1)));
        end
        wr(A1C1, 8'h39);
        chk(16'(sw1.refs), 16'h0000);
        wr(A1C1, 8'h82);
        wr(A2C1, 8'h82);
        chk(16'({cmp1, oe1, cmp2, oe2}), 16'h000F);
        wr(A1C1, 8'h00);
        chk(16'(cmp1), 16'h0000);
    endtask : t_amp1

    task automatic t_cal1();
        logic [7:0] d0;
        logic [7:0] d;
        logic [4:0] tv;
        tv = 5'h00;
        wr(A1C1, 8'h71);
        wr(A1C0, 8'h40);
        chk(16'(sw1), 16'h01B0);
        wr(A1C0, 8'h60);
        chk(16'(sw1), 16'h0170);
        repeat (6) @(posedge ref_clk_in);
        rd(A1C0, d0);
        // Step the trim until the amplifier output flips, as software would.
        for (int t = 1; t < 32 && tv == 5'h00; t++) begin
            wr(A1C0, 8'h60 | 8'(t));
            repeat (6) @(posedge ref_clk_in);
            rd(A1C0, d);
            if (d[7] !== d0[7]) tv = 5'(t);
        end
        chk(16'(tv), 16'(TRIP));
        rd(OSD_ADDR_STATUS, d);
        chk(16'(d), 16'h0001);
        wr(A1C0, {3'b000, tv});
        chk(16'(sw1), 16'h0009);
        rd(A1C0, d);
        chk(16'(d[6:0]), 16'(tv));
    endtask : t_cal1

    task automatic t_amp2();
        wr(A2C1, 8'h01);
        for (int g = 0; g < 8; g++) begin
            wr(A2C2, 8'h08 | 8'(g));
            chk(16'(gain), 16'(g == 0 ? 1 : 8 * g));
            chk(16'(gsw), 16'h0001);
        end
        wr(A2C2, 8'h07);
        chk(16'(gsw), 16'h0000);
        wr(A2C1, 8'h40);
        wr(A2C2, 8'h08);
        chk(16'(gsw), 16'h0000);
        chk(16'(sw2.feedback), 16'h0000);
        chk(16'(pin2), 16'h0000);
        wr(A2C1, 8'h19);
        wr(A2C2, 8'h40);
        chk(16'({xpos, sw2.refs}), 16'h0000);
        wr(A2C1, 8'h11);
        chk(16'({xpos, sw2.refs}), 16'h0008);
        wr(A2C1, 8'h45);
        chk(16'(sw2.feedback), 16'h0001);
        wr(A2C2, 8'h80);
        chk(16'(xneg), 16'h0000);
        wr(A2C1, 8'h41);
        chk(16'(xneg), 16'h0001);
        wr(OSD_ADDR_AMP2_CTRL0, 8'h40);
        chk(16'({xneg, sw2}), 16'h01B0);
        wr(OSD_ADDR_AMP2_CTRL0, 8'h00);
        chk(16'({xneg, sw2}), 16'h0208);
    endtask : t_amp2

    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        #100_000;
        err_count++;
        results();
    end

    initial begin
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_amp1();
        t_cal1();
        t_amp2();
        results();
    end
endmodule : osd_switch_ctrl_test

/* File: hdl/osd_cal_switch.sv */
// Calibration and input-pin switch decode for one amplifier.
module osd_cal_switch
    import osd_pkg::*;
(
    input  wire logic cal_in,
    input  wire logic rsel_in,
    input  wire logic ps_in,
    input  wire logic ns_in,
    output logic      short_out,
    output logic      ref_inv_out,
    output logic      ref_noninv_out,
    output logic      pos_out,
    output logic      neg_out
);
    always_comb begin
        short_out      = cal_in;            // [R1] [R4]
        ref_inv_out    = cal_in && !rsel_in; // [R2]
        ref_noninv_out = cal_in && rsel_in;  // [R2]
        pos_out        = cal_in || ps_in;    // [R9]
        neg_out        = cal_in || ns_in;    // [R9]
    end
endmodule : osd_cal_switch

/* File: hdl/osd_ref_decode.sv */
// Internal reference selector for one amplifier; each amplifier has its own instance.
module osd_ref_decode
    import osd_pkg::*;
(
    input  wire logic [1:0] sel_in,
    input  wire logic       block_in,
    output logic      [2:0] refs_out
);
    // Bit 2 high, bit 1 mid, bit 0 low reference.
    always_comb begin
        refs_out = 3'h0;
        if (!block_in) begin // [R20]
            unique case (sel_in) // [R18]
                OSD_SRC_NONE: refs_out = 3'h0;
                OSD_SRC_HIGH: refs_out = 3'h4;
                OSD_SRC_MID:  refs_out = 3'h2;
                OSD_SRC_LOW:  refs_out = 3'h1;
            endcase
        end
    end
endmodule : osd_ref_decode

/* File: hdl/osd_switch_ctrl.sv */
// Register file and switch/pin decoder for two on-chip amplifiers.
module osd_switch_ctrl
    import osd_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        amp1_comp_in,
    input  wire logic        amp2_comp_in,
    output osd_amp_sw_t      amp1_sw_out,
    output osd_amp_sw_t      amp2_sw_out,
    output logic             amp1_comparator_route_switch_out,
    output logic             amp1_output_enable_out,
    output logic             amp2_output_enable_out,
    output logic             amp2_comparator_route_switch_out,
    output logic             amp2_gain_network_switch_out,
    output logic             amp2_cross_feed_positive_switch_out,
    output logic             amp2_cross_feed_negative_switch_out,
    output logic      [5:0]  amp2_gain_out,
    output osd_pin_t         amp1_pin_out,
    output osd_pin_t         amp2_pin_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] amp1_c0_r;
    logic [7:0] amp1_c1_r;
    logic [7:0] amp2_c0_r;
    logic [7:0] amp2_c1_r;
    logic [7:0] amp2_c2_r;
    logic       amp1_s1_r;
    logic       amp1_s2_r;
    logic       amp1_s3_r;
    logic       amp2_s1_r;
    logic       amp2_s2_r;
    logic       amp2_s3_r;
    logic       amp1_out_r;
    logic       amp2_out_r;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            amp1_c0_r <= OSD_RST_CTRL0;
            amp1_c1_r <= OSD_RST_CTRL1;
            amp2_c0_r <= OSD_RST_CTRL0;
            amp2_c1_r <= OSD_RST_CTRL1;
            amp2_c2_r <= OSD_RST_CTRL2;
        end else if (wr_in) begin
            // Software steps the trim field during calibration. [R3] [R5]
            unique case (addr_in)
                OSD_ADDR_AMP1_CTRL0: amp1_c0_r <= wdata_in & OSD_CTRL0_WMASK;
                OSD_ADDR_AMP1_CTRL1: amp1_c1_r <= wdata_in;
                OSD_ADDR_AMP2_CTRL0: amp2_c0_r <= wdata_in & OSD_CTRL0_WMASK;
                OSD_ADDR_AMP2_CTRL1: amp2_c1_r <= wdata_in;
                OSD_ADDR_AMP2_CTRL2: amp2_c2_r <= wdata_in & OSD_CTRL2_WMASK;
                default: ;
            endcase
        end
    end

    // Comparator outputs are analog and asynchronous, so three stages are used.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            amp1_s1_r <= 1'b0;
            amp1_s2_r <= 1'b0;
            amp1_s3_r <= 1'b0;
            amp2_s1_r <= 1'b0;
            amp2_s2_r <= 1'b0;
            amp2_s3_r <= 1'b0;
        end else begin
            amp1_s1_r <= amp1_comp_in;
            amp1_s2_r <= amp1_s1_r;
            amp1_s3_r <= amp1_s2_r;
            amp2_s1_r <= amp2_comp_in;
            amp2_s2_r <= amp2_s1_r;
            amp2_s3_r <= amp2_s2_r;
        end
    end

    // The status bit only follows once the last two stages agree, filtering glitches.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            amp1_out_r <= 1'b0;
            amp2_out_r <= 1'b0;
        end else begin
            if (amp1_s2_r == amp1_s3_r) amp1_out_r <= amp1_s3_r;
            if (amp2_s2_r == amp2_s3_r) amp2_out_r <= amp2_s3_r;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                OSD_ADDR_AMP1_CTRL0: rdata_out <= {amp1_out_r, amp1_c0_r[6:0]};
                OSD_ADDR_AMP1_CTRL1: rdata_out <= amp1_c1_r;
                OSD_ADDR_AMP2_CTRL0: rdata_out <= {amp2_out_r, amp2_c0_r[6:0]};
                OSD_ADDR_AMP2_CTRL1: rdata_out <= amp2_c1_r;
                OSD_ADDR_AMP2_CTRL2: rdata_out <= amp2_c2_r;
                OSD_ADDR_STATUS:     rdata_out <= {6'h00, amp2_out_r, amp1_out_r};
                default:             rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded control bits.

    logic       amp1_en;
    logic       amp1_cal;
    logic       amp1_ps;
    logic       amp1_ns;
    logic       amp2_en;
    logic       amp2_cal;
    logic       amp2_ps;
    logic       amp2_ns;
    logic       amp2_gen;
    logic       amp1_blk;
    logic       amp2_blk;
    logic       amp2_xp;
    logic [2:0] amp1_refs;
    logic [2:0] amp2_refs;

    assign amp1_en  = amp1_c1_r[OSD_C1_EN];
    assign amp1_cal = amp1_c0_r[OSD_C0_CAL];
    assign amp1_ps  = amp1_c1_r[OSD_C1_PS];
    assign amp1_ns  = amp1_c1_r[OSD_C1_NS];
    assign amp2_en  = amp2_c1_r[OSD_C1_EN];
    assign amp2_cal = amp2_c0_r[OSD_C0_CAL];
    assign amp2_ps  = amp2_c1_r[OSD_C1_PS];
    assign amp2_ns  = amp2_c1_r[OSD_C1_NS];
    assign amp2_gen = amp2_c2_r[OSD_C2_GEN];

    // Pin bit forces the select to none; calibration also holds references open.
    assign amp1_blk = amp1_ps || amp1_cal; // [R7] [R9]
    // Cross feed has priority over the internal references.
    assign amp2_xp  = amp2_c2_r[OSD_C2_X2P] && !amp2_ps && !amp2_cal; // [R12] [R21]
    assign amp2_blk = amp2_ps || amp2_cal || amp2_xp; // [R12]

    osd_ref_decode u_amp1_ref (
        .sel_in   (amp1_c1_r[OSD_C1_PSEL +: 2]),
        .block_in (amp1_blk),
        .refs_out (amp1_refs)
    );

    osd_ref_decode u_amp2_ref (
        .sel_in   (amp2_c1_r[OSD_C1_PSEL +: 2]),
        .block_in (amp2_blk),
        .refs_out (amp2_refs)
    );

    osd_cal_switch u_amp1_cal (
        .cal_in         (amp1_cal),
        .rsel_in        (amp1_c0_r[OSD_C0_RSEL]),
        .ps_in          (amp1_ps),
        .ns_in          (amp1_ns),
        .short_out      (amp1_sw_out.cal_short),
        .ref_inv_out    (amp1_sw_out.ref_inv),
        .ref_noninv_out (amp1_sw_out.ref_noninv),
        .pos_out        (amp1_sw_out.pos_pin),
        .neg_out        (amp1_sw_out.neg_pin)
    );

    osd_cal_switch u_amp2_cal (
        .cal_in         (amp2_cal),
        .rsel_in        (amp2_c0_r[OSD_C0_RSEL]),
        .ps_in          (amp2_ps),
        .ns_in          (amp2_ns),
        .short_out      (amp2_sw_out.cal_short),
        .ref_inv_out    (amp2_sw_out.ref_inv),
        .ref_noninv_out (amp2_sw_out.ref_noninv),
        .pos_out        (amp2_sw_out.pos_pin),
        .neg_out        (amp2_sw_out.neg_pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Switch outputs.

    assign amp1_sw_out.refs     = amp1_refs;
    assign amp1_sw_out.feedback = amp1_en && !amp1_cal && amp1_c1_r[OSD_C1_O2N]; // [R8] [R9]
    assign amp1_comparator_route_switch_out = amp1_c1_r[OSD_C1_CMP]; // [R6]
    assign amp1_output_enable_out = amp1_c1_r[OSD_C1_OEN];

    assign amp2_sw_out.refs     = amp2_refs;
    assign amp2_sw_out.feedback = amp2_en && !amp2_cal && amp2_c1_r[OSD_C1_O2N]; // [R11] [R21]
    assign amp2_comparator_route_switch_out = amp2_c1_r[OSD_C1_CMP];
    assign amp2_output_enable_out = amp2_c1_r[OSD_C1_OEN];
    assign amp2_gain_network_switch_out = amp2_en && !amp2_cal && amp2_gen; // [R10] [R11]
    assign amp2_cross_feed_positive_switch_out = amp2_xp; // [R12]
    assign amp2_cross_feed_negative_switch_out =
        amp2_c2_r[OSD_C2_X2N] && !amp2_ns && !amp2_cal; // [R13] [R21]

    function automatic logic [5:0] gain_of(input logic [2:0] code);
        logic [5:0] g;
        g = (code == 3'h0) ? OSD_GAIN_UNITY : 6'(OSD_GAIN_STEP * {3'h0, code});
        return g;
    endfunction : gain_of

    assign amp2_gain_out = gain_of(amp2_c2_r[2:0]); // [R19]

    ////////////////////////////////////////////////////////////////////////////
    // Pin multiplexer.

    assign amp1_pin_out.out_pin = amp1_en;            // [R14] [R15]
    assign amp1_pin_out.pos_pin = amp1_en && amp1_ps; // [R14] [R16]
    assign amp1_pin_out.neg_pin = amp1_en && amp1_ns; // [R14] [R17]
    // Gain mode ties the inverting pin to the network, so it is claimed too.
    assign amp2_pin_out.out_pin = amp2_en;
    assign amp2_pin_out.pos_pin = amp2_en && amp2_ps;
    assign amp2_pin_out.neg_pin = amp2_en && (amp2_ns || amp2_gen);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    cal_short_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R1]
        amp1_cal |-> amp1_sw_out.cal_short)
        else $error("short open in cal");
    cal_ref_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R2]
        amp1_cal |-> (amp1_sw_out.ref_inv ^ amp1_sw_out.ref_noninv)
        && (amp1_sw_out.ref_noninv == amp1_c0_r[OSD_C0_RSEL]))
        else $error("bad cal reference");
    cal_exit_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R4]
        $fell(amp1_cal) |-> !amp1_sw_out.cal_short && !amp1_sw_out.ref_inv
        && !amp1_sw_out.ref_noninv)
        else $error("cal not left");
    normal_pins_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R4]
        !amp1_cal |-> amp1_sw_out.pos_pin == amp1_ps && amp1_sw_out.neg_pin == amp1_ns)
        else $error("pin switches not restored");
    cmp_route_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R6]
        amp1_comparator_route_switch_out == amp1_c1_r[OSD_C1_CMP])
        else $error("route mismatch");
    pin_refs_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R7]
        amp1_ps |-> amp1_refs == 3'h0)
        else $error("refs closed");
    fb_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R8]
        !amp1_en |-> !amp1_sw_out.feedback)
        else $error("amp1 feedback closed while off");
    cal_open_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R9]
        amp1_cal |-> !amp1_sw_out.feedback && amp1_sw_out.pos_pin
        && amp1_sw_out.neg_pin)
        else $error("cal switches wrong");
    cal_refs_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R9]
        amp1_cal |-> amp1_refs == 3'h0)
        else $error("refs closed in cal");
    gain_on_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R10]
        amp2_en && !amp2_cal && amp2_gen |-> amp2_gain_network_switch_out)
        else $error("gain switches open");
    gain_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R10]
        !amp2_gen |-> !amp2_gain_network_switch_out)
        else $error("gain switches closed");
    gain_sw_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R11]
        !amp2_en |-> !amp2_gain_network_switch_out && !amp2_sw_out.feedback)
        else $error("amp2 off switches");
    prio_pos_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R12]
        amp2_ps |-> !amp2_xp && amp2_refs == 3'h0)
        else $error("priority");
    feed_prio_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R12]
        amp2_xp |-> amp2_refs == 3'h0)
        else $error("feed priority");
    prio_neg_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R13]
        amp2_ns |-> !amp2_cross_feed_negative_switch_out)
        else $error("neg prio");
    pin_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R14]
        !amp1_en |-> amp1_pin_out == 3'h0)
        else $error("pins claimed");
    out_pin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R15]
        amp1_en |-> amp1_pin_out.out_pin)
        else $error("output pin not claimed");
    pos_pin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R16]
        !amp1_ps |-> !amp1_pin_out.pos_pin)
        else $error("positive pin claimed");
    neg_pin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R17]
        !amp1_ns |-> !amp1_pin_out.neg_pin)
        else $error("negative pin claimed");
    ref_none_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R18]
        amp1_c1_r[OSD_C1_PSEL +: 2] == OSD_SRC_NONE |-> amp1_refs == 3'h0)
        else $error("reference closed for none");
    ref_high_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R18]
        !amp1_ps && !amp1_cal && amp1_c1_r[OSD_C1_PSEL +: 2] == OSD_SRC_HIGH
        |-> amp1_refs == 3'h4)
        else $error("high reference not closed");
    gain_unity_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R19]
        amp2_c2_r[2:0] == 3'h0 |-> amp2_gain_out == OSD_GAIN_UNITY)
        else $error("gain not unity");
    gain_step_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R19]
        amp2_c2_r[2:0] != 3'h0 |-> amp2_gain_out == {amp2_c2_r[2:0], 3'h0})
        else $error("gain step wrong");
    gain_val_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R19]
        amp2_c2_r[2:0] == 3'h7 |-> amp2_gain_out == 6'h38)
        else $error("gain 56");
    ref_one_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R20]
        !amp1_ps && !amp1_cal && amp1_c1_r[OSD_C1_PSEL +: 2] != OSD_SRC_NONE
        |-> $onehot(amp1_refs))
        else $error("amp1 reference not one-hot");
    ref_two_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R20]
        !amp2_ps && !amp2_cal && !amp2_xp
        && amp2_c1_r[OSD_C1_PSEL +: 2] != OSD_SRC_NONE |-> $onehot(amp2_refs))
        else $error("amp2 reference not one-hot");
    fb_follow_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R21]
        amp2_en && !amp2_cal && amp2_c1_r[OSD_C1_O2N] |-> amp2_sw_out.feedback)
        else $error("amp2 feedback open");
    feed_neg_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [R21]
        amp2_c2_r[OSD_C2_X2N] && !amp2_ns && !amp2_cal
        |-> amp2_cross_feed_negative_switch_out)
        else $error("negative cross feed open");

endmodule : osd_switch_ctrl

/* File: pkg/osd_pkg.sv */
// Package for the amplifier switch control decoder: register map, fields, resets, types.
// Overview of operation
// R1: Offset-cancel mode on amplifier one closes its calibration short switch.
// R2: In calibration, reference select closes one reference switch: 0 inverting, 1 non-inverting.
// R3: Software steps the five-bit trim until the output status bit toggles.
// R4: Clearing offset-cancel mode returns switches to normal decoding.
// R5: Software repeats the same calibration sequence for amplifier two.
// R6: Comparator route switch follows the output-to-comparator bit.
// R7: Positive-pin bit forces source select to 00, opening internal references.
// R8: Amplifier one disabled opens its feedback switch.
// R9: Calibration closes short and both pin switches, opens feedback and references.
// R10: Gain-enable closes both gain network switches, otherwise both open.
// R11: Amplifier two disabled opens gain network and buffer feedback switches.
// R12: Positive pin beats cross feed, which beats the three internal references.
// R13: Negative pin switch beats the cross feed on the inverting side.
// R14: Amplifier one disabled makes all three port pins general I/O.
// R15: Amplifier one enabled always gives its output pin to the amplifier.
// R16: Positive input pin goes to amplifier only when positive-pin bit set.
// R17: Negative input pin goes to amplifier only when negative-pin bit set; amplifier two also claims it when gain-enable is set.
// R18: Source select: 00 none, 01 high, 10 mid, 11 low reference.
// R19: Gain code 000 gives gain 1, codes 001..111 give 8..56.
// R20: With pin bit and calibration off, codes 01..11 close one reference.
// R21: Buffer feedback and cross feeds follow their own control bits.
package osd_pkg;

    localparam logic [2:0] OSD_ADDR_AMP1_CTRL0 = 3'h0;
    localparam logic [2:0] OSD_ADDR_AMP1_CTRL1 = 3'h1;
    localparam logic [2:0] OSD_ADDR_AMP2_CTRL0 = 3'h2;
    localparam logic [2:0] OSD_ADDR_AMP2_CTRL1 = 3'h3;
    localparam logic [2:0] OSD_ADDR_AMP2_CTRL2 = 3'h4;
    localparam logic [2:0] OSD_ADDR_STATUS     = 3'h5;

    localparam logic [7:0] OSD_RST_CTRL0 = 8'h10;
    localparam logic [7:0] OSD_RST_CTRL1 = 8'h0C;
    localparam logic [7:0] OSD_RST_CTRL2 = 8'h00;
    localparam logic [7:0] OSD_CTRL0_WMASK = 8'h7F;
    localparam logic [7:0] OSD_CTRL2_WMASK = 8'hCF;

    localparam int OSD_C0_OUT  = 7;
    localparam int OSD_C0_CAL  = 6;
    localparam int OSD_C0_RSEL = 5;
    localparam int OSD_C1_CMP  = 7;
    localparam int OSD_C1_O2N  = 6;
    localparam int OSD_C1_PSEL = 4;
    localparam int OSD_C1_PS   = 3;
    localparam int OSD_C1_NS   = 2;
    localparam int OSD_C1_OEN  = 1;
    localparam int OSD_C1_EN   = 0;
    localparam int OSD_C2_X2N  = 7;
    localparam int OSD_C2_X2P  = 6;
    localparam int OSD_C2_GEN  = 3;

    localparam logic [1:0] OSD_SRC_NONE = 2'h0;
    localparam logic [1:0] OSD_SRC_HIGH = 2'h1;
    localparam logic [1:0] OSD_SRC_MID  = 2'h2;
    localparam logic [1:0] OSD_SRC_LOW  = 2'h3;
    localparam logic [5:0] OSD_GAIN_STEP = 6'h08;
    localparam logic [5:0] OSD_GAIN_UNITY = 6'h01;

    typedef struct packed {
        logic       cal_short;
        logic       ref_inv;
        logic       ref_noninv;
        logic       pos_pin;
        logic       neg_pin;
        logic       feedback;
        logic [2:0] refs;
    } osd_amp_sw_t;

    typedef struct packed {
        logic pos_pin;
        logic neg_pin;
        logic out_pin;
    } osd_pin_t;

endpackage : osd_pkg
